// >>> verilog/smbsl_pkg.sv
// Purpose: Shared constants, types and helpers of the SMBus slave register port.
// Assumes: Link-side logic and the main-clock side both import this package.
// Notes:   Three-level strap pins are presented as a two-bit level code.
package smbsl_pkg;

   // Register pointer values
   localparam logic [7:0] REG_ONE_SHOT = 8'h0F;
   localparam logic [7:0] REG_ALERT_CFG = 8'h22;
   localparam logic [7:0] REG_MFG_ID = 8'hFE;
   localparam logic [7:0] REG_DIE_REV = 8'hFF;

   // Alert-count configuration layout; both timeouts start disabled
   localparam logic [7:0] ALERT_CFG_RST = 8'h01;
   localparam int CFG_SCL_TO_BIT = 7;
   localparam int CFG_SDA_TO_BIT = 6;

   // Timeout figure and clock rate
   localparam int TIMEOUT_MS = 25;
   localparam int MCLK_HZ = 100_000_000;
   localparam int TO_CNT_W = 22;
   localparam logic [TO_CNT_W-1:0] TIMEOUT_CYC_DEF = TO_CNT_W'(TIMEOUT_MS * (MCLK_HZ / 1000));

   // Packet error check generator x^8 + x^2 + x + 1
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // Strap level codes and settle wait
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_FLOAT = 2'h1;
   localparam logic [1:0] PIN_HIGH = 2'h2;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // Slave addresses, first pin then second pin
   localparam logic [6:0] ADDR_LL = 7'h18;
   localparam logic [6:0] ADDR_LF = 7'h19;
   localparam logic [6:0] ADDR_LH = 7'h1A;
   localparam logic [6:0] ADDR_FL = 7'h29;
   localparam logic [6:0] ADDR_FF = 7'h2A;
   localparam logic [6:0] ADDR_FH = 7'h2B;
   localparam logic [6:0] ADDR_HL = 7'h4C;
   localparam logic [6:0] ADDR_HF = 7'h4D;
   localparam logic [6:0] ADDR_HH = 7'h4E;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] BYTE_ADDR = 3'h0;
   localparam logic [2:0] BYTE_PTR = 3'h1;
   localparam logic [2:0] BYTE_DATA = 3'h2;
   localparam logic [2:0] BYTE_PEC = 3'h3;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAIT} smbsl_state_t;

   typedef struct packed {
      smbsl_state_t state;
      logic [3:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [7:0] shift;
      logic rw;
      logic mack;
      logic [7:0] ptr;
      logic [7:0] crc;
      logic [7:0] wdata;
      logic pend;
      logic sda_oe;
      logic sda_o;
      logic busy;
      logic [7:0] alert_cfg;
      logic [6:0] slave_addr;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic [1:0] lsb_s1;
      logic [1:0] lsb_s2;
      logic [1:0] msb_s1;
      logic [1:0] msb_s2;
      logic scl_s1;
      logic scl_s2;
      logic scl_prev;
      logic sda_s1;
      logic sda_s2;
      logic sda_prev;
      logic to_s1;
      logic to_s2;
      logic to_seen;
      logic os_tgl;
   } smbsl_link_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic sda_s1;
      logic sda_s2;
      logic scl_en_s1;
      logic scl_en_s2;
      logic sda_en_s1;
      logic sda_en_s2;
      logic busy_s1;
      logic busy_s2;
      logic os_s1;
      logic os_s2;
      logic os_seen;
      logic one_shot;
      logic [TO_CNT_W-1:0] scl_cnt;
      logic [TO_CNT_W-1:0] sda_cnt;
      logic to_tgl;
      logic to_pulse;
   } smbsl_main_t;

   // Idle bus lines are high, so the samplers start high to avoid false edges
   localparam smbsl_link_t LINK_RST = '{state: ST_IDLE, alert_cfg: ALERT_CFG_RST, scl_s1: 1'b1, scl_s2: 1'b1,
                                        scl_prev: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_prev: 1'b1, default: '0};
   localparam smbsl_main_t MAIN_RST = '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, default: '0};

   function automatic logic [7:0] smbsl_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   function automatic logic [6:0] smbsl_addr_lookup(input logic [1:0] msb, input logic [1:0] lsb);
      logic [6:0] a;
      a = ADDR_FF;
      case ({msb, lsb})
         {PIN_LOW, PIN_LOW}: a = ADDR_LL;
         {PIN_LOW, PIN_FLOAT}: a = ADDR_LF;
         {PIN_LOW, PIN_HIGH}: a = ADDR_LH;
         {PIN_FLOAT, PIN_LOW}: a = ADDR_FL;
         {PIN_FLOAT, PIN_HIGH}: a = ADDR_FH;
         {PIN_HIGH, PIN_LOW}: a = ADDR_HL;
         {PIN_HIGH, PIN_FLOAT}: a = ADDR_HF;
         {PIN_HIGH, PIN_HIGH}: a = ADDR_HH;
         default: a = ADDR_FF;
      endcase
      return a;
   endfunction

endpackage

// >>> verilog/smbsl_port.sv
// Purpose: SMBus slave register port: addressing, pointer, config register, PEC, timeouts, one-shot.
// Assumes: link_clk runs free and oversamples SCL/SDA; mclk is the device clock.
// Notes:   Protocol engine on link_clk; timeouts and the one-shot strobe on mclk.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Enabled timeout aborts the transaction after 25 ms idle; both disabled after reset.
// RULE2: Config register bit 7 enables the clock-line timeout.
// RULE3: Config register bit 6 enables the data-line timeout.
// RULE4: PEC byte is checked or sent only when the master clocks an extra byte.
// RULE5: PEC is CRC-8 with polynomial x^8+x^2+x+1 over all transaction bytes.
// RULE6: Slave address comes from the two three-level strap pins per the table.
// RULE7: Strap pins are latched once after reset; later changes are ignored.
// RULE8: Start is SDA falling with SCL high; then eight bits MSB first.
// RULE9: Matching address is acknowledged; a mismatch idles until the next start.
// RULE10: Direction bit 0 is a master write, 1 a master read.
// RULE11: Nine clocks per byte; SDA rising with SCL high is a stop.
// RULE12: The master ends a write with a stop on the tenth clock.
// RULE13: Master NACKs the last read byte and stops; device releases SDA.
// RULE14: Direction is fixed per transaction; writes of one or two bytes, reads of one.
// RULE15: First written byte loads the register pointer.
// RULE16: Second written byte goes to the register the pointer selects.
// RULE17: A read returns the register at the current pointer without reloading it.
// RULE18: Read and write pointer decodes may differ; write-only locations read as zero.
// RULE19: Writing pointer 0F starts one measurement; the data byte is discarded.
// RULE20: After a timeout both lines are released and the port waits for a start.
module smbsl_port
   import smbsl_pkg::*;
#(
   parameter logic [TO_CNT_W-1:0] TIMEOUT_CYCLES = TIMEOUT_CYC_DEF,
   parameter logic [7:0] MFG_ID = 8'h5A,   // Arbitrary value
   parameter logic [7:0] DIE_REV = 8'h01   // Arbitrary value
) (
   // Device clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link oversampling clock
   input wire logic link_clk,
   // Bus pins
   input wire logic scl,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe,
   // Address straps, level codes
   input wire logic [1:0] addr_select_pin_lsb,
   input wire logic [1:0] addr_select_pin_msb,
   // Device-side status
   output logic [6:0] slave_addr,
   output logic one_shot_start,
   output logic bus_timeout
);

   smbsl_link_t l_q;
   smbsl_link_t l_d;
   smbsl_main_t m_q;
   smbsl_main_t m_d;
   logic rst_link_s1;
   logic rst_link;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic to_evt;
   logic [7:0] rd_byte;

   // Link reset: asserts at once, releases on a link_clk edge
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         rst_link_s1 <= 1'b1;
         rst_link <= 1'b1;
      end else begin
         rst_link_s1 <= 1'b0;
         rst_link <= rst_link_s1;
      end
   end

   assign scl_rise = l_q.scl_s2 & ~l_q.scl_prev;
   assign scl_fall = ~l_q.scl_s2 & l_q.scl_prev;
   assign start_cond = l_q.scl_s2 & l_q.scl_prev & l_q.sda_prev & ~l_q.sda_s2; // RULE8
   assign stop_cond = l_q.scl_s2 & l_q.scl_prev & ~l_q.sda_prev & l_q.sda_s2; // RULE11
   assign to_evt = l_q.to_s2 ^ l_q.to_seen;

   // Write-only pointers such as the one-shot read back as zero
   always_comb begin
      unique case (l_q.ptr)
         REG_ALERT_CFG: rd_byte = l_q.alert_cfg; // RULE18
         REG_MFG_ID: rd_byte = MFG_ID;
         REG_DIE_REV: rd_byte = DIE_REV;
         default: rd_byte = '0;
      endcase
   end

   always_comb begin
      l_d = l_q;
      l_d.scl_s1 = scl;
      l_d.scl_s2 = l_q.scl_s1;
      l_d.scl_prev = l_q.scl_s2;
      l_d.sda_s1 = serial_data_line_i;
      l_d.sda_s2 = l_q.sda_s1;
      l_d.sda_prev = l_q.sda_s2;
      l_d.lsb_s1 = addr_select_pin_lsb;
      l_d.lsb_s2 = l_q.lsb_s1;
      l_d.msb_s1 = addr_select_pin_msb;
      l_d.msb_s2 = l_q.msb_s1;
      l_d.to_s1 = m_q.to_tgl;
      l_d.to_s2 = l_q.to_s1;
      l_d.sda_o = 1'b0;
      if (!l_q.strap_done) begin
         // Wait for the strap samplers to fill, then latch once
         if (l_q.strap_cnt == STRAP_WAIT) begin
            l_d.slave_addr = smbsl_addr_lookup(l_q.msb_s2, l_q.lsb_s2); // RULE6
            l_d.strap_done = 1'b1; // RULE7
         end else begin
            l_d.strap_cnt = l_q.strap_cnt + 2'h1;
         end
      end else if (to_evt) begin
         // Pending write is dropped: an aborted frame must not land
         l_d.to_seen = l_q.to_s2;
         l_d.state = ST_IDLE; // RULE20
         l_d.sda_oe = 1'b0; // RULE20
         l_d.pend = 1'b0; // RULE1
      end else if (start_cond || stop_cond) begin
         // A repeated start also closes the previous write
         if (l_q.pend) begin
            l_d.pend = 1'b0;
            if (l_q.ptr == REG_ONE_SHOT) begin
               l_d.os_tgl = ~l_q.os_tgl; // RULE19
            end else if (l_q.ptr == REG_ALERT_CFG) begin
               l_d.alert_cfg = l_q.wdata; // RULE16
            end
         end
         l_d.sda_oe = 1'b0;
         l_d.bit_cnt = '0;
         l_d.byte_cnt = BYTE_ADDR;
         l_d.state = start_cond ? ST_RX : ST_IDLE; // RULE14
      end else begin
         unique case (l_q.state)
            ST_IDLE, ST_WAIT: begin
               l_d.sda_oe = 1'b0; // RULE9
            end
            ST_RX: begin
               if (scl_rise) begin
                  l_d.shift = {l_q.shift[6:0], l_q.sda_s2}; // RULE8
                  l_d.bit_cnt = l_q.bit_cnt + 4'h1;
               end else if (scl_fall && l_q.bit_cnt == BITS_PER_BYTE) begin
                  l_d.bit_cnt = '0;
                  l_d.byte_cnt = l_q.byte_cnt + 3'h1;
                  l_d.state = ST_ACK;
                  l_d.sda_oe = 1'b1; // RULE11
                  l_d.crc = smbsl_crc8(l_q.crc, l_q.shift); // RULE5
                  unique case (l_q.byte_cnt)
                     BYTE_ADDR: begin
                        l_d.crc = smbsl_crc8(CRC_INIT, l_q.shift); // RULE5
                        l_d.rw = l_q.shift[0]; // RULE10
                        if (l_q.shift[7:1] != l_q.slave_addr) begin
                           l_d.state = ST_WAIT; // RULE9
                           l_d.sda_oe = 1'b0;
                        end
                     end
                     BYTE_PTR: l_d.ptr = l_q.shift; // RULE15
                     BYTE_DATA: begin
                        l_d.wdata = l_q.shift; // RULE16
                        l_d.pend = 1'b1;
                     end
                     BYTE_PEC: begin
                        // Bad check byte is refused and the write is discarded
                        if (l_q.shift != l_q.crc) begin
                           l_d.pend = 1'b0; // RULE4
                           l_d.state = ST_WAIT;
                           l_d.sda_oe = 1'b0;
                        end
                     end
                     default: begin
                        l_d.state = ST_WAIT; // RULE14
                        l_d.sda_oe = 1'b0;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  l_d.sda_oe = 1'b0;
                  if (l_q.rw) begin
                     l_d.shift = rd_byte; // RULE17
                     l_d.sda_oe = ~rd_byte[7];
                     l_d.crc = smbsl_crc8(l_q.crc, rd_byte); // RULE5
                     l_d.state = ST_TX;
                  end else begin
                     l_d.state = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  l_d.bit_cnt = l_q.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (l_q.bit_cnt == BITS_PER_BYTE) begin
                     l_d.sda_oe = 1'b0; // RULE13
                     l_d.bit_cnt = '0;
                     l_d.state = ST_TXACK;
                  end else begin
                     l_d.shift = {l_q.shift[6:0], 1'b0};
                     l_d.sda_oe = ~l_q.shift[6];
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise) begin
                  l_d.mack = ~l_q.sda_s2;
               end else if (scl_fall) begin
                  if (l_q.mack && l_q.byte_cnt == BYTE_PTR) begin
                     // Master asked for one more byte: send the check byte
                     l_d.shift = l_q.crc; // RULE4
                     l_d.sda_oe = ~l_q.crc[7];
                     l_d.byte_cnt = BYTE_DATA;
                     l_d.state = ST_TX;
                  end else begin
                     l_d.state = ST_WAIT; // RULE13
                  end
               end
            end
         endcase
      end
      l_d.busy = (l_d.state != ST_IDLE);
   end

   always_ff @(posedge link_clk or posedge rst_link) begin
      if (rst_link) begin
         l_q <= LINK_RST;
      end else begin
         l_q <= l_d;
      end
   end

   // Main clock side: timeouts count from its own samples of the lines
   always_comb begin
      m_d = m_q;
      m_d.scl_s1 = scl;
      m_d.scl_s2 = m_q.scl_s1;
      m_d.sda_s1 = serial_data_line_i;
      m_d.sda_s2 = m_q.sda_s1;
      m_d.scl_en_s1 = l_q.alert_cfg[CFG_SCL_TO_BIT];
      m_d.scl_en_s2 = m_q.scl_en_s1;
      m_d.sda_en_s1 = l_q.alert_cfg[CFG_SDA_TO_BIT];
      m_d.sda_en_s2 = m_q.sda_en_s1;
      m_d.busy_s1 = l_q.busy;
      m_d.busy_s2 = m_q.busy_s1;
      m_d.os_s1 = l_q.os_tgl;
      m_d.os_s2 = m_q.os_s1;
      m_d.os_seen = m_q.os_s2;
      m_d.one_shot = m_q.os_s2 ^ m_q.os_seen; // RULE19
      m_d.to_pulse = 1'b0;
      // A line held low during a frame counts; any release restarts the wait
      m_d.scl_cnt = (m_q.busy_s2 && m_q.scl_en_s2 && !m_q.scl_s2) ? m_q.scl_cnt + 1'b1 : '0; // RULE2
      m_d.sda_cnt = (m_q.busy_s2 && m_q.sda_en_s2 && !m_q.sda_s2) ? m_q.sda_cnt + 1'b1 : '0; // RULE3
      if (m_q.scl_cnt == TIMEOUT_CYCLES - 1'b1 || m_q.sda_cnt == TIMEOUT_CYCLES - 1'b1) begin
         m_d.to_tgl = ~m_q.to_tgl; // RULE1
         m_d.to_pulse = 1'b1;
         m_d.scl_cnt = '0;
         m_d.sda_cnt = '0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         m_q <= MAIN_RST;
      end else begin
         m_q <= m_d;
      end
   end

   assign serial_data_line_o = l_q.sda_o;
   assign serial_data_line_oe = l_q.sda_oe;
   assign slave_addr = l_q.slave_addr;
   assign one_shot_start = m_q.one_shot;
   assign bus_timeout = m_q.to_pulse;

endmodule
`default_nettype wire

// >>> dv/smbsl_host_model.sv
// Purpose: Bus master model that drives SCL and pulls SDA for the slave port.
// Assumes: Open-drain SDA with a pull-up; the bench resolves the wire level.
// Notes:   SCL stands high between frames; each phase lasts ten link cycles.
`timescale 1ns/1ps
`default_nettype none
module smbsl_host_model (
   // Link clock and resolved data wire
   input wire logic link_clk,
   input wire logic sda,
   // Driven lines
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge link_clk);
   endtask
   // Data moves only one phase after SCL falls, so no edge on SDA can look like start or stop
   task automatic bitx(input logic b, output logic r);
      scl <= 1'b0;
      half();
      sda_low <= ~b;
      half();
      scl <= 1'b1;
      half();
      r = sda;
   endtask
   task automatic start();
      logic r;
      bitx(1'b1, r);
      sda_low <= 1'b1;
      half();
   endtask
   task automatic stop();
      logic r;
      bitx(1'b0, r);
      sda_low <= 1'b0;
      half();
   endtask
   task automatic wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd(output logic [7:0] b, input logic mack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         b[i] = r;
      end
      bitx(~mack, r);
   endtask
   task automatic hold_low(input int n);
      scl <= 1'b0;
      half();
      sda_low <= 1'b0;
      repeat (n) half();
   endtask
endmodule
`default_nettype wire

// >>> dv/smbsl_port_checker.sv
// Purpose: Assertions on the pins of the SMBus slave port.
// Assumes: Bound to smbsl_port; sees only its ports.
// Notes:   Pin checks run on link_clk, strobe checks on mclk.
`timescale 1ns/1ps
`default_nettype none
module smbsl_port_checker (
   // Clocks and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic link_clk,
   // Bus
   input wire logic scl,
   input wire logic serial_data_line_i,
   input wire logic serial_data_line_o,
   input wire logic serial_data_line_oe,
   // Straps and status
   input wire logic [1:0] addr_select_pin_lsb,
   input wire logic [1:0] addr_select_pin_msb,
   input wire logic [6:0] slave_addr,
   input wire logic one_shot_start,
   input wire logic bus_timeout
);
   sequence s_fire;
      bus_timeout;
   endsequence
   sequence s_released;
      ##[1:20] !serial_data_line_oe;
   endsequence
   a_open_drain: assert property (@(posedge link_clk) disable iff (rst) serial_data_line_o == 1'b0)
      else $error("SDA drive value not low");
   a_oe_scl_low: assert property (@(posedge link_clk) disable iff (rst) $changed(serial_data_line_oe) |-> !scl)
      else $error("SDA drive changed while SCL high");
   a_addr_legal: assert property (@(posedge link_clk) disable iff (rst) slave_addr != 7'h00 |->
      slave_addr inside {7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E})
      else $error("Slave address outside strap table");
   a_addr_hold: assert property (@(posedge link_clk) disable iff (rst) slave_addr != 7'h00 |=> $stable(slave_addr))
      else $error("Slave address moved after latch");
   a_os_pulse: assert property (@(posedge mclk) disable iff (rst) one_shot_start |=> !one_shot_start)
      else $error("One-shot strobe longer than a cycle");
   a_os_idle: assert property (@(posedge mclk) disable iff (rst) one_shot_start |-> scl && serial_data_line_i)
      else $error("One-shot strobe while bus busy");
   a_to_pulse: assert property (@(posedge mclk) disable iff (rst) bus_timeout |=> !bus_timeout)
      else $error("Timeout strobe longer than a cycle");
   a_to_line: assert property (@(posedge mclk) disable iff (rst) bus_timeout |-> !scl || !serial_data_line_i)
      else $error("Timeout with both lines high");
   a_to_release: assert property (@(posedge mclk) disable iff (rst) s_fire |-> s_released)
      else $error("SDA not released after timeout");
endmodule
bind smbsl_port smbsl_port_checker u_chk (.mclk(mclk), .rst(rst), .link_clk(link_clk), .scl(scl),
   .serial_data_line_i(serial_data_line_i), .serial_data_line_o(serial_data_line_o),
   .serial_data_line_oe(serial_data_line_oe), .addr_select_pin_lsb(addr_select_pin_lsb),
   .addr_select_pin_msb(addr_select_pin_msb), .slave_addr(slave_addr), .one_shot_start(one_shot_start),
   .bus_timeout(bus_timeout));
`default_nettype wire

// >>> dv/test_smbus_slave_register_port.sv
// Purpose: Self-checking bench for the SMBus slave register port.
// Assumes: Host model drives the bus; straps are level codes 0 low, 1 open, 2 high.
// Notes:   Timeout shortened to 500 mclk: above the longest low run of any frame here (nine bits),
//          well below the held-low span of the abort test.
`timescale 1ns/1ps
`default_nettype none
module test_smbus_slave_register_port;
   logic mclk, rst, link_clk, a;
   logic [1:0] addr_select_pin_lsb, addr_select_pin_msb;
   logic serial_data_line_o, serial_data_line_oe, one_shot_start, bus_timeout;
   logic [6:0] slave_addr;
   wire logic scl, sda_low;
   wire logic sda_w = ~((serial_data_line_oe & ~serial_data_line_o) | sda_low);
   int err_total = 0;
   int check_count = 0;
   int os_cnt = 0;
   int to_cnt = 0;
   logic [7:0] d, q[$];
   logic [6:0] at [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};
   localparam logic [7:0] AW = 8'h9C;
   localparam logic [7:0] AR = 8'h9D;
   smbsl_port #(.TIMEOUT_CYCLES(22'd500)) dut (.mclk(mclk), .rst(rst), .link_clk(link_clk), .scl(scl),
      .serial_data_line_i(sda_w), .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe),
      .addr_select_pin_lsb(addr_select_pin_lsb), .addr_select_pin_msb(addr_select_pin_msb),
      .slave_addr(slave_addr), .one_shot_start(one_shot_start), .bus_timeout(bus_timeout));
   smbsl_host_model host (.link_clk(link_clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end
   always @(posedge mclk) begin
      if (one_shot_start === 1'b1) os_cnt <= os_cnt + 1;
      if (bus_timeout === 1'b1) to_cnt <= to_cnt + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] b[$]);
      logic [7:0] c;
      c = 8'h00;
      foreach (b[i]) begin
         c ^= b[i];
         repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   task automatic send(input logic [7:0] b[$], output logic ack);
      logic k;
      ack = 1'b1;
      host.start();
      foreach (b[i]) begin
         host.wr(b[i], k);
         ack &= k;
      end
      host.stop();
   endtask
   // With pec set the master acknowledges the data and clocks the check byte as well
   task automatic rd_reg(output logic [7:0] v, input logic pec);
      logic k;
      logic [7:0] p;
      host.start();
      host.wr(AR, k);
      host.rd(v, pec);
      if (pec) begin
         host.rd(p, 1'b0);
         chk(p, crc8({AR, v}));
      end
      host.stop();
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      addr_select_pin_lsb = 2'h0;
      addr_select_pin_msb = 2'h0;
      for (int i = 0; i < 9; i++) begin
         @(posedge mclk);
         rst <= 1'b1;
         addr_select_pin_msb <= 2'(i / 3);
         addr_select_pin_lsb <= 2'(i % 3);
         repeat (4) @(posedge mclk);
         rst <= 1'b0;
         repeat (20) @(posedge mclk);
         addr_select_pin_msb <= 2'(2 - i / 3);
         addr_select_pin_lsb <= 2'h1;
         repeat (20) @(posedge mclk);
         chk({1'b0, slave_addr}, {1'b0, at[i]});
      end
      send({AW, 8'h22}, a);
      chk(8'(a), 8'h01);
      rd_reg(d, 1'b0);
      chk(d, 8'h01);
      send({AW, 8'h22, 8'hC1}, a);
      rd_reg(d, 1'b1);
      chk(d, 8'hC1);
      send({8'h30, 8'h0F, 8'h00}, a);
      chk(8'(a), 8'h00);
      rd_reg(d, 1'b0);
      chk(d, 8'hC1);
      q = {AW, 8'h22, 8'hC0};
      q.push_back(crc8(q));
      send(q, a);
      chk(8'(a), 8'h01);
      q = {AW, 8'h22, 8'h41};
      q.push_back(~crc8(q));
      send(q, a);
      chk(8'(a), 8'h00);
      rd_reg(d, 1'b0);
      chk(d, 8'hC0);
      send({AW, 8'h0F, 8'h5A}, a);
      repeat (20) @(posedge mclk);
      chk(8'(os_cnt), 8'h01);
      rd_reg(d, 1'b0);
      chk(d, 8'h00);
      // Both timeouts are enabled here; SCL is held low across the acknowledge for longer than the timeout
      host.start();
      for (int i = 7; i >= 0; i--) host.bitx(AW[i], a);
      host.hold_low(60);
      chk(8'(to_cnt), 8'h01);
      chk({7'h00, serial_data_line_oe}, 8'h00);
      host.stop();
      send({AW, 8'h22, 8'h01}, a);
      chk(8'(a), 8'h01);
      rd_reg(d, 1'b0);
      chk(d, 8'h01);
      test_done();
   end
endmodule
`default_nettype wire
